//--- dmx_pkg.sv
// Package of shared constants and types for the single-channel transfer core.
// Assumes a 10 MHz system clock and an APB register bus with 32-bit data.
`default_nettype none
package dmx_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int LEN_W = 17;
  localparam int FIFO_DEPTH = 4;
  localparam logic [16:0] MAX_LEN = 17'h10000;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SRC = 12'h004;
  localparam logic [11:0] OFS_DST = 12'h008;
  localparam logic [11:0] OFS_LEN = 12'h00c;
  localparam logic [11:0] OFS_MATCH = 12'h010;
  localparam logic [11:0] OFS_STAT = 12'h014;
  localparam logic [11:0] OFS_COUNT = 12'h018;
  localparam int CB_EN = 0;
  localparam int CB_MODE_LO = 1;
  localparam int CB_MODE_HI = 2;
  localparam int CB_FLYBY = 3;
  localparam int CB_SRC_IO = 4;
  localparam int CB_DST_IO = 5;
  localparam int CB_SRC_DN = 6;
  localparam int CB_DST_DN = 7;
  localparam int CB_SRC_FIX = 8;
  localparam int CB_DST_FIX = 9;
  localparam int SB_BUSY = 0;
  localparam int SB_DONE = 1;
  localparam int SB_MATCH = 2;
  localparam int SB_OWN = 3;
  localparam int SB_READY = 4;
  localparam int MATCH_MASK_LO = 8;
  typedef enum logic [1:0] {
    DMX_MODE_BYTE = 2'h0,
    DMX_MODE_BURST = 2'h1,
    DMX_MODE_CONT = 2'h2
  } dmx_mode_t;
  typedef enum logic [5:0] {
    DMX_IDLE = 6'h01,
    DMX_REQ = 6'h02,
    DMX_RD = 6'h04,
    DMX_WR = 6'h08,
    DMX_FLY = 6'h10,
    DMX_REL = 6'h20
  } dmx_state_t;
endpackage
`default_nettype wire

//--- dmx_fifo_if.sv
// Valid/ready carrier between the core and its byte FIFO.
// Assumes both ends share one clock.
`default_nettype none
interface dmx_fifo_if #(parameter int W = 8);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

//--- dmx_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`default_nettype none
module dmx_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  dmx_fifo_if.fifo f
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } dmx_fifo_st_t;
  dmx_fifo_st_t s_q, s_d;
  logic push, pop;
  assign f.in_ready = (s_q.cnt != (PW+1)'(DEPTH));
  assign f.out_valid = (s_q.cnt != '0);
  assign f.out_data = s_q.mem[s_q.rp];
  assign push = f.in_valid && f.in_ready;
  assign pop = f.out_valid && f.out_ready;
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = f.in_data;
      s_d.wp = PW'((s_q.wp + 1'b1) % DEPTH);
    end
    if (pop) begin
      s_d.rp = PW'((s_q.rp + 1'b1) % DEPTH);
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  a_fifo_no_over: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_q.cnt <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule
`default_nettype wire

//--- dmx_core.sv
// Single-channel transfer engine: takes the system bus and moves a block.
// Assumes an APB master for the registers and a host that grants the bus.
`default_nettype none
module dmx_core (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rdy_pin,
  input wire logic bus_ack,
  output logic bus_req,
  output logic [15:0] src_addr,
  output logic [15:0] dst_addr,
  output logic addr_oe_n,
  output logic mem_rd,
  output logic io_rd,
  output logic mem_wr,
  output logic io_wr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n
);
  typedef struct packed {
    dmx_pkg::dmx_state_t st;
    logic [9:0] ctrl;
    logic [15:0] src_start;
    logic [15:0] dst_start;
    logic [16:0] len;
    logic [15:0] match;
    logic [15:0] src;
    logic [15:0] dst;
    logic [16:0] count;
    logic done;
    logic hit;
    logic [1:0] rdy_sync;
    logic ack_s1;
    logic ack_s2;
    logic [7:0] dout;
    logic drv;
    logic srd;
    logic swr;
    logic [31:0] rdata;
  } dmx_st_t;
  dmx_st_t s_q, s_d;
  dmx_fifo_if #(.W(dmx_pkg::DATA_W)) fb ();
  dmx_fifo #(.W(dmx_pkg::DATA_W), .DEPTH(dmx_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .f(fb)
  );
  logic rdy, ack, apb_acc, reg_busy, block_end, flyby, last;
  dmx_pkg::dmx_mode_t mode;
  logic [7:0] mask;
  assign rdy = s_q.rdy_sync[1];
  assign ack = s_q.ack_s2;
  assign mode = dmx_pkg::dmx_mode_t'(
    s_q.ctrl[dmx_pkg::CB_MODE_HI:dmx_pkg::CB_MODE_LO]);
  assign flyby = s_q.ctrl[dmx_pkg::CB_FLYBY];
  assign mask = s_q.match[15:dmx_pkg::MATCH_MASK_LO];
  assign apb_acc = psel && penable;
  // Registers are locked while the engine owns the bus.
  assign reg_busy = (s_q.st != dmx_pkg::DMX_IDLE);
  assign pready = 1'b1;
  assign pslverr = apb_acc && reg_busy && pwrite;
  assign prdata = s_q.rdata;
  assign block_end = (s_q.count == s_q.len);
  assign last = (s_q.count + 17'h1 == s_q.len);
  assign bus_req = (s_q.st != dmx_pkg::DMX_IDLE) &&
                   (s_q.st != dmx_pkg::DMX_REL);
  assign src_addr = s_q.src;
  assign dst_addr = s_q.dst;
  assign addr_oe_n = !s_q.drv;
  assign data_out = s_q.dout;
  assign data_oe_n = !(s_q.drv && s_q.swr);
  // Strobes are decoded by port kind so flyby pairs fall out naturally.
  assign mem_rd = s_q.srd && !s_q.ctrl[dmx_pkg::CB_SRC_IO];
  assign io_rd = s_q.srd && s_q.ctrl[dmx_pkg::CB_SRC_IO];
  assign mem_wr = s_q.swr && !s_q.ctrl[dmx_pkg::CB_DST_IO];
  assign io_wr = s_q.swr && s_q.ctrl[dmx_pkg::CB_DST_IO];
  assign fb.in_valid = (s_q.st == dmx_pkg::DMX_RD);
  assign fb.in_data = data_in;
  assign fb.out_ready = (s_q.st == dmx_pkg::DMX_WR);
  function automatic logic [15:0] step(input logic [15:0] a,
      input logic dn, input logic fix);
    if (fix) begin
      step = a;
    end else if (dn) begin
      step = a - 16'h1;
    end else begin
      step = a + 16'h1;
    end
  endfunction
  always_comb begin
    logic moved;
    logic [7:0] byte_in;
    moved = 1'b0;
    byte_in = data_in;
    s_d = s_q;
    s_d.rdy_sync = {s_q.rdy_sync[0], rdy_pin};
    s_d.ack_s1 = bus_ack;
    s_d.ack_s2 = s_q.ack_s1;
    s_d.srd = 1'b0;
    s_d.swr = 1'b0;
    s_d.rdata = '0;
    // Read data is captured during the setup cycle so that it already
    // stands in the access cycle, when the master samples it.
    if (psel && !pwrite) begin
      case (paddr)
        dmx_pkg::OFS_CTRL: s_d.rdata = 32'(s_q.ctrl);
        dmx_pkg::OFS_SRC: s_d.rdata = 32'(s_q.src_start);
        dmx_pkg::OFS_DST: s_d.rdata = 32'(s_q.dst_start);
        dmx_pkg::OFS_LEN: s_d.rdata = 32'(s_q.len);
        dmx_pkg::OFS_MATCH: s_d.rdata = 32'(s_q.match);
        dmx_pkg::OFS_STAT: s_d.rdata = 32'({rdy, ack, s_q.hit, s_q.done,
                                            reg_busy});
        dmx_pkg::OFS_COUNT: s_d.rdata = 32'(s_q.count);
        default: s_d.rdata = '0;
      endcase
    end
    if (apb_acc && pwrite && !reg_busy) begin
      case (paddr)
        dmx_pkg::OFS_CTRL: s_d.ctrl = pwdata[9:0];
        dmx_pkg::OFS_SRC: s_d.src_start = pwdata[15:0];
        dmx_pkg::OFS_DST: s_d.dst_start = pwdata[15:0];
        dmx_pkg::OFS_LEN: begin
          // Lengths above the maximum are clipped to 64 Kbyte.
          if (pwdata[16:0] > dmx_pkg::MAX_LEN) begin
            s_d.len = dmx_pkg::MAX_LEN;
          end else begin
            s_d.len = pwdata[16:0];
          end
        end
        dmx_pkg::OFS_MATCH: s_d.match = pwdata[15:0];
        dmx_pkg::OFS_STAT: begin
          if (pwdata[dmx_pkg::SB_DONE]) begin
            s_d.done = 1'b0;
          end
          if (pwdata[dmx_pkg::SB_MATCH]) begin
            s_d.hit = 1'b0;
          end
        end
        default: ;
      endcase
    end
    case (s_q.st)
      dmx_pkg::DMX_IDLE: begin
        s_d.drv = 1'b0;
        // Host must have loaded start addresses and length already.
        if (s_q.ctrl[dmx_pkg::CB_EN] && rdy && !block_end) begin
          s_d.st = dmx_pkg::DMX_REQ;
        end else if (s_q.ctrl[dmx_pkg::CB_EN] && s_q.count == '0) begin
          s_d.src = s_q.src_start;
          s_d.dst = s_q.dst_start;
        end
      end
      dmx_pkg::DMX_REQ: begin
        if (ack) begin
          s_d.drv = 1'b1;
          s_d.st = flyby ? dmx_pkg::DMX_FLY : dmx_pkg::DMX_RD;
          s_d.srd = 1'b1;
          s_d.swr = flyby;
        end
      end
      dmx_pkg::DMX_RD: begin
        // Byte lands in the internal buffer; written in a later cycle.
        s_d.st = dmx_pkg::DMX_WR;
        s_d.swr = 1'b1;
        s_d.dout = byte_in;
        moved = 1'b0;
      end
      dmx_pkg::DMX_WR, dmx_pkg::DMX_FLY: begin
        moved = 1'b1;
        if (s_q.st == dmx_pkg::DMX_WR) begin
          byte_in = fb.out_data;
        end
      end
      dmx_pkg::DMX_REL: begin
        s_d.drv = 1'b0;
        if (!ack) begin
          s_d.st = dmx_pkg::DMX_IDLE;
        end
      end
      default: s_d.st = dmx_pkg::DMX_IDLE;
    endcase
    if (moved) begin
      if (((byte_in ^ s_q.match[7:0]) & ~mask) == 8'h0) begin
        s_d.hit = 1'b1;
      end
      s_d.count = s_q.count + 17'h1;
      s_d.src = step(s_q.src, s_q.ctrl[dmx_pkg::CB_SRC_DN],
                     s_q.ctrl[dmx_pkg::CB_SRC_FIX]);
      s_d.dst = step(s_q.dst, s_q.ctrl[dmx_pkg::CB_DST_DN],
                     s_q.ctrl[dmx_pkg::CB_DST_FIX]);
      if (last) begin
        s_d.done = 1'b1;
        s_d.ctrl[dmx_pkg::CB_EN] = 1'b0;
        s_d.st = dmx_pkg::DMX_REL;
      end else begin
        case (mode)
          dmx_pkg::DMX_MODE_BURST: begin
            s_d.st = rdy ? s_d.st : dmx_pkg::DMX_REL;
          end
          dmx_pkg::DMX_MODE_CONT: s_d.st = s_d.st;
          default: s_d.st = dmx_pkg::DMX_REL;
        endcase
        if (s_d.st != dmx_pkg::DMX_REL) begin
          s_d.st = dmx_pkg::DMX_REQ;
        end
        // Continuous mode waits in the request state holding the bus.
        if (mode == dmx_pkg::DMX_MODE_CONT && !rdy) begin
          s_d.st = dmx_pkg::DMX_REQ;
        end
      end
    end
    if (s_q.st == dmx_pkg::DMX_REQ && ack && s_q.drv &&
        mode == dmx_pkg::DMX_MODE_CONT && !rdy) begin
      s_d.st = dmx_pkg::DMX_REQ;
      s_d.srd = 1'b0;
      s_d.swr = 1'b0;
    end
    if (apb_acc && pwrite && !reg_busy && paddr == dmx_pkg::OFS_CTRL &&
        pwdata[dmx_pkg::CB_EN]) begin
      s_d.count = '0;
      s_d.src = s_q.src_start;
      s_d.dst = s_q.dst_start;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: dmx_pkg::DMX_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end
  a_drive_needs_ack: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(s_q.drv) |-> s_q.ack_s2)
    else $error("bus driven without acknowledge");
  a_flyby_strobes: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_q.st == dmx_pkg::DMX_FLY) |-> (s_q.srd && s_q.swr))
    else $error("flyby strobes not together");
  a_seq_read_then: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_q.st == dmx_pkg::DMX_RD) |=> (s_q.st == dmx_pkg::DMX_WR && s_q.swr))
    else $error("sequential write missing");
  a_count_steps: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_q.st == dmx_pkg::DMX_WR) |=> (s_q.count == $past(s_q.count) + 17'h1))
    else $error("count did not step");
  a_done_releases: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(s_q.done) |-> (s_q.st == dmx_pkg::DMX_REL))
    else $error("done without release");
  a_byte_mode_rel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == dmx_pkg::DMX_MODE_BYTE && s_q.st == dmx_pkg::DMX_FLY) |=>
    (s_q.st == dmx_pkg::DMX_REL))
    else $error("byte mode kept bus");
  a_start_on_ready: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_q.st == dmx_pkg::DMX_IDLE ##1 s_q.st == dmx_pkg::DMX_REQ) |->
    $past(rdy))
    else $error("started without ready");
  a_len_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_q.len <= dmx_pkg::MAX_LEN)
    else $error("length above maximum");
endmodule
`default_nettype wire

//--- dmx_host_model.sv
// Host and peripheral model facing the system bus side of the transfer core.
// Assumes one clock; the bench sets the Ready level and clears the counters.
`default_nettype none
module dmx_host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic rdy_en,
  input wire logic bus_req,
  input wire logic [15:0] src_addr,
  input wire logic [15:0] dst_addr,
  input wire logic addr_oe_n,
  input wire logic mem_rd,
  input wire logic io_rd,
  input wire logic mem_wr,
  input wire logic io_wr,
  input wire logic [7:0] data_out,
  output logic rdy_pin,
  output logic bus_ack,
  output logic [7:0] data_in,
  output int wr_cnt,
  output int fly_cnt,
  output int req_cnt,
  output int viol,
  output logic [15:0] last_src,
  output logic [15:0] last_dst,
  output logic [7:0] last_dat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] held_q;
  logic req_q;
  wire rd = mem_rd | io_rd;
  wire wr = mem_wr | io_wr;
  // A released data bus flips every cycle, so a stale sample cannot pass.
  assign data_in = rd ? (src_addr[7:0] ^ 8'h5a) : ~held_q;
  assign rdy_pin = rdy_en;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
      req_q <= 1'b0;
      held_q <= 8'h00;
      wr_cnt <= 0;
      fly_cnt <= 0;
      req_cnt <= 0;
      viol <= 0;
    end else begin
      bus_ack <= bus_req;
      req_q <= bus_req;
      held_q <= data_in;
      if (clr) begin
        wr_cnt <= 0;
        fly_cnt <= 0;
        req_cnt <= 0;
        viol <= 0;
      end else begin
        if (bus_req && !req_q) req_cnt <= req_cnt + 1;
        if (rd) last_src <= src_addr;
        if (rd && wr) fly_cnt <= fly_cnt + 1;
        if (wr) begin
          wr_cnt <= wr_cnt + 1;
          last_dst <= dst_addr;
          last_dat <= data_out;
        end
        // Strobes without the grant, or a same-space pair, are flagged.
        if ((rd || wr) && (!bus_ack || addr_oe_n)) viol <= viol + 1;
        if ((mem_rd && mem_wr) || (io_rd && io_wr)) viol <= viol + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb_dmx_core.sv
// Self-checking bench for the transfer core: APB set-up, bus model checks.
// Assumes the core answers APB at once and the model grants every request.
`default_nettype none
module tb_dmx_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic clr = 0, rdy_en = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic pready, pslverr, rdy_pin, bus_ack, bus_req, addr_oe_n;
  logic mem_rd, io_rd, mem_wr, io_wr, data_oe_n;
  logic [15:0] src_addr, dst_addr, last_src, last_dst;
  logic [7:0] data_in, data_out, last_dat;
  int wr_cnt, fly_cnt, req_cnt, viol, err_count = 0, n_checks = 0;
  dmx_core i_dmx_core (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rdy_pin, .bus_ack, .bus_req,
    .src_addr, .dst_addr, .addr_oe_n, .mem_rd, .io_rd, .mem_wr, .io_wr,
    .data_in, .data_out, .data_oe_n);
  dmx_host_model i_dmx_host_model (.sys_clk, .rst_n, .clr, .rdy_en,
    .bus_req, .src_addr, .dst_addr, .addr_oe_n, .mem_rd, .io_rd, .mem_wr,
    .io_wr, .data_out, .rdy_pin, .bus_ack, .data_in, .wr_cnt, .fly_cnt,
    .req_cnt, .viol, .last_src, .last_dst, .last_dat);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    err_count++;
    finish_test;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    // Registers are touched only while the host holds the bus.
    while (bus_ack !== 1'b0) @(posedge sys_clk);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    // Read data is taken at the very edge that completes the access.
    rd_q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] mode,
      input logic fly, input logic sio, input logic dio, input logic sdn);
    cfg = {25'h0, sdn, dio, sio, fly, mode, 1'b1};
  endfunction
  task automatic start(input logic [31:0] ctl, input logic [15:0] s,
      input logic [15:0] d, input logic [16:0] n, input logic [31:0] m);
    @(posedge sys_clk) clr <= 1'b1;
    @(posedge sys_clk) clr <= 1'b0;
    apb(1'b1, dmx_pkg::OFS_STAT, 32'h6);
    apb(1'b1, dmx_pkg::OFS_SRC, {16'h0, s});
    apb(1'b1, dmx_pkg::OFS_DST, {16'h0, d});
    apb(1'b1, dmx_pkg::OFS_LEN, {15'h0, n});
    apb(1'b1, dmx_pkg::OFS_MATCH, m);
    apb(1'b1, dmx_pkg::OFS_CTRL, ctl);
  endtask
  task automatic wait_wr(input int n, input logic idle);
    int k;
    k = 0;
    while ((wr_cnt < n || (idle && (bus_req || bus_ack))) && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (4) @(posedge sys_clk);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(dmx_pkg::OFS_STAT, 32'h0);
    rd_chk(12'h01c, 32'h0);
    apb(1'b1, dmx_pkg::OFS_LEN, 32'h10000);
    rd_chk(dmx_pkg::OFS_LEN, 32'h10000);
    $display("test registers done");
    start(cfg(dmx_pkg::DMX_MODE_BYTE, 0, 1, 0, 1), 16'h0050, 16'h0400, 3,
          32'ha5);
    repeat (20) @(posedge sys_clk);
    chk(req_cnt, 0);
    @(posedge sys_clk) rdy_en <= 1'b1;
    wait_wr(3, 1'b1);
    chk(req_cnt, 3);
    chk(last_src, 16'h004e);
    chk(last_dat, 8'h14);
    rd_chk(dmx_pkg::OFS_STAT, 32'h12);
    $display("test byte mode done");
    start(cfg(dmx_pkg::DMX_MODE_BURST, 0, 0, 1, 0), 16'h0100, 16'h0200, 4,
          32'hfe00);
    wait_wr(4, 1'b1);
    chk(wr_cnt, 4);
    chk(fly_cnt, 0);
    chk(last_dst, 16'h0203);
    chk(last_dat, 8'h59);
    rd_chk(dmx_pkg::OFS_COUNT, 32'h4);
    rd_chk(dmx_pkg::OFS_STAT, 32'h16);
    $display("test sequential burst done");
    for (int m = 1; m <= 2; m++) begin
      start(cfg(2'(m), 0, 0, 0, 0), 16'h0600, 16'h0700, 10, 32'ha5);
      wait_wr(2, 1'b0);
      @(posedge sys_clk) rdy_en <= 1'b0;
      repeat (20) @(posedge sys_clk);
      chk(bus_req, m == 2);
      @(posedge sys_clk) rdy_en <= 1'b1;
      wait_wr(10, 1'b1);
      chk(req_cnt, 3 - m);
      rd_chk(dmx_pkg::OFS_COUNT, 32'ha);
      $display("test ready pause mode %0d done", m);
    end
    for (int d = 0; d <= 1; d++) begin
      start(cfg(dmx_pkg::DMX_MODE_CONT, 1, d == 1, d == 0, 1), 16'h0300,
            16'h0040, 4, 32'ha5);
      wait_wr(4, 1'b1);
      chk(fly_cnt, 4);
      chk(viol, 0);
      chk(last_src, 16'h02fd);
      chk(last_dst, 16'h0043);
      $display("test flyby direction %0d done", d);
    end
    finish_test;
  end
endmodule
`default_nettype wire
